// ===== common/ssa_pkg.sv
// shared constants, timing counts and helpers for the parallel readout link
package ssa_pkg;
	localparam int NUM_PAIRS = 3;
	localparam int NUM_CH = 6;
	localparam int RES_W = 16;
	localparam int CLK_MHZ = 20;
	// conversion time in ns; least time rounds up to whole cycles
	localparam int T_CONV_NS = 3000;
	localparam int CONV_CYCLES = (T_CONV_NS * CLK_MHZ + 999) / 1000;
	// host strobe widths in ns
	localparam int T_START_LOW_NS = 100;
	localparam int START_LOW_CYCLES = (T_START_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RD_LOW_NS = 100;
	localparam int RD_LOW_CYCLES = (T_RD_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RD_HIGH_NS = 50;
	localparam int RD_HIGH_CYCLES = (T_RD_HIGH_NS * CLK_MHZ + 999) / 1000;
	// host register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RESULT0 = 8'h08;
	localparam int CTRL_START_LSB = 0;
	localparam int CTRL_BYTE_MODE = 3;
	localparam int CTRL_HBF = 4;
	localparam int CTRL_SERIAL = 5;
	localparam int STAT_BUSY = 0;
	localparam int STAT_SEQ_ACTIVE = 1;
	localparam int STAT_RESULTS_VALID = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [5:0] pair_to_chan(input logic [2:0] pairs);
		return {pairs[2], pairs[2], pairs[1], pairs[1], pairs[0], pairs[0]};
	endfunction : pair_to_chan

	// next set channel above cur, wrapping; cur = 5 yields the lowest
	function automatic logic [2:0] next_chan(input logic [5:0] mask, input logic [2:0] cur);
		logic [2:0] res;
		logic found;
		int idx;
		res = cur;
		found = 1'b0;
		for (int k = 1; k <= NUM_CH; k++) begin
			idx = (int'(cur) + k) % NUM_CH;
			if (!found && mask[idx]) begin
				res = 3'(idx);
				found = 1'b1;
			end
		end
		return res;
	endfunction : next_chan
endpackage : ssa_pkg

// ===== common/ssa_par_if.sv
// parallel readout pins between converter and host
`timescale 1ns/1ps
interface ssa_par_if;
	logic interface_select;
	logic byte_mode;
	logic [2:0] pair_conv_start;
	logic cs_n;
	logic rd_n;
	logic high_byte_first_o;
	logic high_byte_first_oe;
	logic busy;
	logic [15:0] data_out;
	logic data_oe_hi;
	logic data_oe_lo;
	logic [15:0] data_line;

	// resolved bus level; an undriven line reads low
	assign data_line[15:8] = data_oe_hi ? data_out[15:8] : 8'h00;
	assign data_line[7] = data_oe_lo ? data_out[7] : (high_byte_first_oe & high_byte_first_o);
	assign data_line[6:0] = data_oe_lo ? data_out[6:0] : 7'h00;

	modport dev (input interface_select, input byte_mode, input pair_conv_start, input cs_n, input rd_n,
		input data_line, output busy, output data_out, output data_oe_hi, output data_oe_lo);
	modport host (output interface_select, output byte_mode, output pair_conv_start, output cs_n,
		output rd_n, output high_byte_first_o, output high_byte_first_oe, input busy, input data_line);
endinterface : ssa_par_if

// ===== src/ssa_conv_timer.sv
// on-chip conversion timer: busy for a fixed number of cycles
`timescale 1ns/1ps
module ssa_conv_timer #(
	parameter int CYCLES = ssa_pkg::CONV_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic start,
	output logic busy,
	output logic done
);
	logic [$clog2(CYCLES+1)-1:0] count_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start && !busy) begin
				count_reg <= ($clog2(CYCLES+1))'(CYCLES - 1);
				busy <= 1'b1;
			end else if (busy) begin
				if (count_reg == '0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count_reg <= count_reg - 1'b1;
				end
			end
		end
	end
endmodule : ssa_conv_timer

// ===== src/ssa_adc_device.sv
// converter end: pair-wise starts, busy, ordered word/byte readout
`timescale 1ns/1ps
// Behaviour
// - low interface select enables parallel port
// - word/byte select picks 16-bit or byte
// - host pulses start low then high
// - rising start edge begins simultaneous conversion
// - start inputs map to channel pairs 1-3
// - conversion lasts 3 us on internal timer
// - busy falls at end; inputs track again
// - results held until host reads them
// - data lines driven only during chip-select read
// - read strobe alone advances with select tied
// - host reads only after busy falls
// - word mode: one read per converted channel
// - results ascend by channel, unsampled skipped
// - host never starts while busy high
// - host avoids starting during a read sequence
// - unused start inputs held high
// - byte mode: pin 7 selects order, upper lines
// - order select low gives low byte first
// - byte mode: six results take twelve reads
// - host leaves lower seven lines unconnected
// - results are twos complement
module ssa_adc_device #(
	parameter int CONV_CYCLES = ssa_pkg::CONV_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ssa_pkg::NUM_CH*ssa_pkg::RES_W-1:0] sample_in,
	output logic track_mode,
	ssa_par_if.dev port
);
	logic [2:0] start_prev_reg;
	logic [2:0] start_rise;
	logic par_sel;
	logic conv_go;
	logic busy_w;
	logic done_w;
	logic [2:0] pairs_pend_reg;
	logic [5:0] chan_mask_reg;
	logic [5:0] chan_mask_next;
	logic [ssa_pkg::RES_W-1:0] result_reg [ssa_pkg::NUM_CH];
	logic read_act;
	logic read_prev_reg;
	logic read_end;
	logic [2:0] ch_reg;
	logic phase_reg;
	logic high_byte_first_reg;
	logic [15:0] data_out_reg;
	logic [15:0] word_sel;
	logic show_high;

	// serial interface is not provided here; serial select just parks the port
	assign par_sel = ~port.interface_select;

	// start inputs are synchronous; edge found against last sampled level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_prev_reg <= 3'h7;
		end else if (ce) begin
			start_prev_reg <= port.pair_conv_start;
		end
	end

	assign start_rise = port.pair_conv_start & ~start_prev_reg;
	// edges while busy are dropped; the host is not allowed to send them
	assign conv_go = par_sel && (start_rise != 3'h0) && !busy_w;

	ssa_conv_timer #(
		.CYCLES(CONV_CYCLES)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.start(conv_go),
		.busy(busy_w),
		.done(done_w)
	);

	assign port.busy = busy_w;
	// track-and-hold returns to tracking as busy falls
	assign track_mode = ~busy_w;

	// remember which pairs this conversion covers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pairs_pend_reg <= 3'h0;
		end else if (ce && conv_go) begin
			pairs_pend_reg <= start_rise;
		end
	end

	// sample captured at the start edge of its own pair only
	generate
		for (genvar c = 0; c < ssa_pkg::NUM_CH; c++) begin : g_chan
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					result_reg[c] <= 16'h0000;
				end else if (ce && conv_go && start_rise[c/2]) begin
					// input already carries the signed code
					result_reg[c] <= sample_in[c*ssa_pkg::RES_W +: ssa_pkg::RES_W];
				end
			end
		end
	endgenerate

	assign chan_mask_next = ssa_pkg::pair_to_chan(pairs_pend_reg);

	// readable set replaced only when a new conversion completes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_mask_reg <= 6'h00;
		end else if (ce && done_w) begin
			chan_mask_reg <= chan_mask_next;
		end
	end

	// chip select may be tied low, so read strobe alone frames each read
	assign read_act = par_sel && !port.cs_n && !port.rd_n;
	assign read_end = read_prev_reg && !read_act;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			read_prev_reg <= 1'b0;
		end else if (ce) begin
			read_prev_reg <= read_act;
		end
	end

	// order select is sampled only while the device is not driving the bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_byte_first_reg <= 1'b0;
		end else if (ce && port.byte_mode && !read_act) begin
			high_byte_first_reg <= port.data_line[7];
		end
	end

	// read pointer: channel plus byte phase; completion wins over a read end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch_reg <= 3'h0;
			phase_reg <= 1'b0;
		end else if (ce) begin
			if (done_w) begin
				ch_reg <= ssa_pkg::next_chan(chan_mask_next, 3'h5);
				phase_reg <= 1'b0;
			end else if (read_end) begin
				if (port.byte_mode && !phase_reg) begin
					phase_reg <= 1'b1;
				end else begin
					phase_reg <= 1'b0;
					// skipping unsampled channels; wraps after the last one
					ch_reg <= ssa_pkg::next_chan(chan_mask_reg, ch_reg);
				end
			end
		end
	end

	assign word_sel = result_reg[ch_reg];
	// first byte is the high one only when order select is high
	assign show_high = high_byte_first_reg ^ phase_reg;

	// output word registered every cycle from the read pointer, so it is ready one cycle after the strobe falls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_out_reg <= 16'h0000;
		end else if (ce) begin
			if (port.byte_mode) begin
				data_out_reg <= {show_high ? word_sel[15:8] : word_sel[7:0], 8'h00};
			end else begin
				data_out_reg <= word_sel;
			end
		end
	end

	assign port.data_out = data_out_reg;
	assign port.data_oe_hi = read_act;
	// lower lines stay released in byte mode so line 7 can carry order select
	assign port.data_oe_lo = read_act && !port.byte_mode;
endmodule : ssa_adc_device

// ===== src/ssa_adc_host.sv
// host end: AXI4-Lite registers driving starts and collecting results
`timescale 1ns/1ps
module ssa_adc_host #(
	parameter int START_LOW = ssa_pkg::START_LOW_CYCLES,
	parameter int RD_LOW = ssa_pkg::RD_LOW_CYCLES,
	parameter int RD_HIGH = ssa_pkg::RD_HIGH_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ssa_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ssa_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	ssa_par_if.host port
);
	typedef enum logic [2:0] {H_IDLE, H_START_LO, H_WAIT_BUSY, H_WAIT_DONE, H_RD_LO, H_RD_HI} ssa_hstate_t;

	ssa_hstate_t state_reg;
	logic [7:0] cnt_reg;
	logic aw_have_reg, w_have_reg;
	logic [ssa_pkg::ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write;
	logic wr_ctrl;
	logic [2:0] start_req;
	logic byte_mode_reg, hbf_reg, serial_reg;
	logic [2:0] pairs_reg;
	logic [5:0] mask_reg;
	logic [2:0] ch_reg;
	logic phase_reg;
	logic valid_reg;
	logic [15:0] result_reg [ssa_pkg::NUM_CH];
	logic [2:0] rd_idx;

	assign s_axi_awready = !aw_have_reg;
	assign s_axi_wready = !w_have_reg;
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wr_ctrl = do_write && (awaddr_reg == ssa_pkg::OFS_CTRL) && wstrb_reg[0];
	assign start_req = wr_ctrl ? wdata_reg[ssa_pkg::CTRL_START_LSB +: 3] : 3'h0;

	// write address and data accepted in either order, answered once both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ssa_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && !aw_have_reg) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_reg) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg == ssa_pkg::OFS_CTRL) ? ssa_pkg::RESP_OKAY : ssa_pkg::RESP_SLVERR;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// mode bits; a change during a sequence takes effect at once, in the running sequence
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			byte_mode_reg <= 1'b0;
			hbf_reg <= 1'b0;
			serial_reg <= 1'b0;
		end else if (ce && wr_ctrl) begin
			byte_mode_reg <= wdata_reg[ssa_pkg::CTRL_BYTE_MODE];
			hbf_reg <= wdata_reg[ssa_pkg::CTRL_HBF];
			serial_reg <= wdata_reg[ssa_pkg::CTRL_SERIAL];
		end
	end

	assign port.interface_select = serial_reg;
	assign port.byte_mode = byte_mode_reg;
	assign port.high_byte_first_o = hbf_reg;
	assign port.high_byte_first_oe = byte_mode_reg;

	// sequencer: start pulse, wait busy, read every converted channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= H_IDLE;
			cnt_reg <= 8'h00;
			pairs_reg <= ssa_pkg::CTRL_RESET;
			mask_reg <= 6'h00;
			ch_reg <= 3'h0;
			phase_reg <= 1'b0;
			valid_reg <= 1'b0;
			port.pair_conv_start <= 3'h7;
			port.cs_n <= 1'b1;
			port.rd_n <= 1'b1;
		end else if (ce) begin
			case (state_reg)
				H_IDLE: begin
					// requests during a sequence are dropped, never overlapping a read
					// serial bit of this same write decides; the stored bit is one write late
					if (start_req != 3'h0 && !wdata_reg[ssa_pkg::CTRL_SERIAL] && !port.busy) begin
						pairs_reg <= start_req;
						port.pair_conv_start <= ~start_req;
						cnt_reg <= 8'(START_LOW - 1);
						valid_reg <= 1'b0;
						state_reg <= H_START_LO;
					end
				end
				H_START_LO: begin
					if (cnt_reg == 8'h00) begin
						port.pair_conv_start <= 3'h7;
						state_reg <= H_WAIT_BUSY;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				H_WAIT_BUSY: begin
					if (port.busy) begin
						state_reg <= H_WAIT_DONE;
					end
				end
				H_WAIT_DONE: begin
					if (!port.busy) begin
						mask_reg <= ssa_pkg::pair_to_chan(pairs_reg);
						ch_reg <= ssa_pkg::next_chan(ssa_pkg::pair_to_chan(pairs_reg), 3'h5);
						phase_reg <= 1'b0;
						port.cs_n <= 1'b0;
						port.rd_n <= 1'b0;
						cnt_reg <= 8'(RD_LOW - 1);
						state_reg <= H_RD_LO;
					end
				end
				H_RD_LO: begin
					if (cnt_reg == 8'h00) begin
						port.cs_n <= 1'b1;
						port.rd_n <= 1'b1;
						cnt_reg <= 8'(RD_HIGH - 1);
						state_reg <= H_RD_HI;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				H_RD_HI: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else if (byte_mode_reg && !phase_reg) begin
						phase_reg <= 1'b1;
						port.cs_n <= 1'b0;
						port.rd_n <= 1'b0;
						cnt_reg <= 8'(RD_LOW - 1);
						state_reg <= H_RD_LO;
					end else if (ssa_pkg::next_chan(mask_reg, ch_reg) <= ch_reg) begin
						valid_reg <= 1'b1;
						state_reg <= H_IDLE;
					end else begin
						phase_reg <= 1'b0;
						ch_reg <= ssa_pkg::next_chan(mask_reg, ch_reg);
						port.cs_n <= 1'b0;
						port.rd_n <= 1'b0;
						cnt_reg <= 8'(RD_LOW - 1);
						state_reg <= H_RD_LO;
					end
				end
				default: begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	// bus sampled in the last low cycle of each read strobe
	generate
		for (genvar c = 0; c < ssa_pkg::NUM_CH; c++) begin : g_res
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					result_reg[c] <= 16'h0000;
				end else if (ce && state_reg == H_RD_LO && cnt_reg == 8'h00 && ch_reg == 3'(c)) begin
					if (!byte_mode_reg) begin
						result_reg[c] <= port.data_line;
					end else if (hbf_reg ^ phase_reg) begin
						result_reg[c][15:8] <= port.data_line[15:8];
					end else begin
						result_reg[c][7:0] <= port.data_line[15:8];
					end
				end
			end
		end
	endgenerate

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx = 3'((s_axi_araddr - ssa_pkg::OFS_RESULT0) >> 2);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ssa_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= ssa_pkg::RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				if (s_axi_araddr == ssa_pkg::OFS_CTRL) begin
					s_axi_rdata <= {26'h0, serial_reg, hbf_reg, byte_mode_reg, pairs_reg};
				end else if (s_axi_araddr == ssa_pkg::OFS_STATUS) begin
					s_axi_rdata <= {29'h0, valid_reg, state_reg != H_IDLE, port.busy};
				end else if (s_axi_araddr >= ssa_pkg::OFS_RESULT0 && s_axi_araddr[1:0] == 2'h0
						&& s_axi_araddr < ssa_pkg::OFS_RESULT0 + 8'h18) begin
					s_axi_rdata <= {16'h0000, result_reg[rd_idx]};
				end else begin
					s_axi_rresp <= ssa_pkg::RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : ssa_adc_host

// ===== tb/ssa_link_checker.sv
// concurrent checks on the parallel readout link between the two ends
`timescale 1ns/1ps
module ssa_link_checker #(
	parameter int CONV_CYCLES = ssa_pkg::CONV_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic interface_select,
	input wire logic byte_mode,
	input wire logic [2:0] pair_conv_start,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic high_byte_first_oe,
	input wire logic busy,
	input wire logic data_oe_hi,
	input wire logic data_oe_lo
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	int busy_cnt;
	logic [2:0] start_q;
	logic rd_act;
	logic start_edge;

	assign rd_act = !cs_n && !rd_n;
	assign start_edge = |(pair_conv_start & ~start_q);

	// counts busy samples so the conversion length is checked exactly
	// frozen cycles are not conversion time
	always_ff @(posedge aclk) begin
		if (ce) begin
			busy_cnt <= busy ? busy_cnt + 1 : 0;
		end
	end

	always_ff @(posedge aclk) begin
		start_q <= pair_conv_start;
	end

	chk_oe_gated: assert property (data_oe_hi |-> rd_act && !interface_select)
		else $error("data lines driven outside a read");
	chk_read_drives: assert property (rd_act && !interface_select |-> data_oe_hi)
		else $error("read strobe did not enable the data lines");
	chk_lane_width: assert property (data_oe_hi |-> data_oe_lo == !byte_mode)
		else $error("wrong data lanes for the selected width");
	chk_byte_order_pin: assert property (byte_mode && data_oe_hi |-> high_byte_first_oe)
		else $error("order select line not driven by host in byte mode");
	chk_start_takes: assert property (start_edge && !busy && !interface_select |=> busy)
		else $error("start edge did not raise busy");
	chk_serial_parked: assert property (start_edge && interface_select && !busy |=> !busy)
		else $error("conversion started with serial select");
	chk_conv_exact: assert property ($fell(busy) |-> busy_cnt == CONV_CYCLES)
		else $error("conversion length wrong");
	chk_conv_bound: assert property (busy |-> busy_cnt < CONV_CYCLES)
		else $error("busy held too long");
	chk_no_start_busy: assert property (start_edge |-> !busy)
		else $error("start issued while busy");
	chk_read_idle: assert property (rd_act |-> !busy)
		else $error("read while busy");
	chk_start_pulse: assert property ($fell(pair_conv_start[0]) |-> !pair_conv_start[0] [*2])
		else $error("start pulse too short");
	chk_strobe_width: assert property ($fell(rd_n) |-> !rd_n [*2])
		else $error("read strobe too short");

	cov_conv_done: cover property ($fell(busy));
	cov_word_read: cover property (data_oe_lo);
	cov_byte_read: cover property (data_oe_hi && byte_mode);
	cov_all_pairs: cover property (pair_conv_start == 3'h0);
endmodule : ssa_link_checker

// ===== tb/ssa_adc_readout_tb.sv
// self-checking bench: register orders through the host end into the converter end
`timescale 1ns/1ps
module ssa_adc_readout_tb;
	localparam int CONV = ssa_pkg::CONV_CYCLES;
	logic aclk;
	logic aresetn;
	logic ce;
	logic [ssa_pkg::NUM_CH*ssa_pkg::RES_W-1:0] sample_in;
	logic track_mode;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int fails, samples_checked;
	logic [15:0] seen[$];
	logic [15:0] held;
	logic rd_prev;

	ssa_par_if par_if();
	ssa_adc_device #(.CONV_CYCLES(CONV)) ssa_adc_device_inst(.aclk, .aresetn, .ce, .sample_in,
		.track_mode, .port(par_if));
	ssa_adc_host ssa_adc_host_inst(.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .port(par_if));
	ssa_link_checker #(.CONV_CYCLES(CONV)) ssa_link_checker_inst(.aclk, .aresetn, .ce,
		.interface_select(par_if.interface_select), .byte_mode(par_if.byte_mode),
		.pair_conv_start(par_if.pair_conv_start), .cs_n(par_if.cs_n), .rd_n(par_if.rd_n),
		.high_byte_first_oe(par_if.high_byte_first_oe), .busy(par_if.busy),
		.data_oe_hi(par_if.data_oe_hi), .data_oe_lo(par_if.data_oe_lo));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// the value on the bus in the last cycle of each read is what the host got
	always @(negedge aclk) begin
		if (!par_if.cs_n && !par_if.rd_n) held = par_if.data_line;
		else if (rd_prev) seen.push_back(held);
		rd_prev = !par_if.cs_n && !par_if.rd_n;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_verdict();
		$display("checked %0d, wrong %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic stall();
		fails++;
		$display("wrong value wait expected answer seen timeout");
		give_verdict();
	endtask : stall

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic aw_t, w_t, b_t;
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			if (b_t) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 100) stall();
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ar_t, v_t;
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			v_t = s_axi_rvalid;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			if (v_t) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 100) stall();
	endtask : axi_rd

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] rr;
		axi_rd(a, d, rr);
		check(what, e, d & m);
		check(what, {30'h0, er}, {30'h0, rr});
	endtask : rd_chk

	// one conversion through the host; twice adds a start request while the first is running
	task automatic run(input logic [2:0] pairs, input logic bytes, input logic hbf, input logic twice);
		logic [31:0] st;
		logic [15:0] v;
		int n;
		int k;
		seen.delete();
		axi_wr(ssa_pkg::OFS_CTRL, {26'h0, 1'b0, hbf, bytes, pairs}, r);
		if (twice) axi_wr(ssa_pkg::OFS_CTRL, {26'h0, 1'b0, hbf, bytes, 3'h7}, r);
		for (n = 0; n < 100 && par_if.busy !== 1'b1; n++) @(negedge aclk);
		check("track while busy", 32'h0, {31'h0, track_mode});
		for (n = 0; n < 400; n++) begin
			axi_rd(ssa_pkg::OFS_STATUS, st, r);
			if (st[2:0] === 3'b100) break;
		end
		if (n == 400) stall();
		check("track after", 32'h1, {31'h0, track_mode});
		check("idle starts", 32'h7, {29'h0, par_if.pair_conv_start});
		k = 0;
		for (int c = 0; c < 6; c++) begin
			if (pairs[c/2]) begin
				v = sample_in[16*c +: 16];
				if (!bytes) begin
					check("word", {16'h0, v}, {16'h0, seen[k]});
				end else begin
					check("first byte", {16'h0, hbf ? v[15:8] : v[7:0], hbf, 7'h0}, {16'h0, seen[k]});
					k++;
					check("second byte", {16'h0, hbf ? v[7:0] : v[15:8], hbf, 7'h0}, {16'h0, seen[k]});
				end
				k++;
			end
		end
		check("read count", 32'(k), 32'(seen.size()));
		if (pairs[0]) rd_chk("result0", ssa_pkg::OFS_RESULT0, 32'hFFFF, {16'h0, sample_in[15:0]}, 2'h0);
		$display("test pairs %b bytes %b order %b done", pairs, bytes, hbf);
	endtask : run

	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		sample_in = 96'hFF00_00FF_A5C3_1234_7FFE_8001;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk("ctrl reset", ssa_pkg::OFS_CTRL, 32'h3F, 32'h0, ssa_pkg::RESP_OKAY);
		rd_chk("status reset", ssa_pkg::OFS_STATUS, 32'h7, 32'h0, ssa_pkg::RESP_OKAY);
		rd_chk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0, ssa_pkg::RESP_SLVERR);
		axi_wr(ssa_pkg::OFS_STATUS, 32'h1, r);
		check("status write", {30'h0, ssa_pkg::RESP_SLVERR}, {30'h0, r});
		$display("test registers done");
		axi_wr(ssa_pkg::OFS_CTRL, 32'h27, r);
		repeat (CONV + 20) @(negedge aclk);
		check("serial busy", 32'h0, {31'h0, par_if.busy});
		check("serial reads", 32'h0, 32'(seen.size()));
		$display("test serial select done");
		run(3'b101, 1'b0, 1'b0, 1'b0);
		run(3'b010, 1'b0, 1'b0, 1'b1);
		run(3'b111, 1'b1, 1'b0, 1'b0);
		run(3'b100, 1'b1, 1'b1, 1'b0);
		run(3'b001, 1'b0, 1'b0, 1'b0);
		axi_wr(ssa_pkg::OFS_CTRL, 32'h7, r);
		repeat (20) @(posedge aclk);
		ce <= 1'b0;
		repeat (CONV + 20) @(posedge aclk);
		@(negedge aclk);
		check("frozen busy", 32'h1, {31'h0, par_if.busy});
		check("frozen track", 32'h0, {31'h0, track_mode});
		$display("test clock enable done");
		@(posedge aclk);
		ce <= 1'b1;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check("busy after reset", 32'h0, {31'h0, par_if.busy});
		run(3'b111, 1'b0, 1'b0, 1'b0);
		give_verdict();
	end
endmodule : ssa_adc_readout_tb
